// [logic/uhp_pkg.sv]
// Functional notes
// - mux select low: address on separate inputs, data on both byte lanes
// - mux select high: low address and low data share the low byte lines
// - mux select high: separate address inputs are ignored
// - muxed mode latches address and select at latch strobe falling edge
// - reads and writes need chip select (latched in muxed mode), except single address dma under grant
// - low read strobe with chip selected drives addressed data on bus
// - low write strobe with chip selected accepts bus data
// - interrupt output asserted while enabled source pends; low active unless irq_pol_high is set
// - dma request output, low active after reset, asks for fifo service
// - in single address mode, asserted dma grant allows fifo access without an address
// - only the endpoint 1 bulk fifo raises dma requests
// - endpoint 1 dma supports 8 and 16 bit, demand and single modes
// - demand mode: request asserted once a valid packet is received
// - demand mode: request held until whole packet moved, then dropped
// - single mode: request dropped after each transfer, bus freed
// - sources: packet ready per fifo, setup ready, suspend
// - each interrupt source gated by its own enable bit
// - every fifo has full/empty flags and can redo its packet
// - endpoints 1 and 2 direction set by software; 64 byte fifos (the endpoint 1 receive fifo here holds FIFO_DEPTH 8 entries)
// - single address dma ignores chip select and address; grant selects
// - dual address dma ignores grant; fifo chosen by select and address
package uhp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOV8_NS     = 63;
  localparam int RECOV16_NS    = 105;
  localparam logic [3:0] RECOV8_CYC =
    4'((RECOV8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOV16_CYC =
    4'((RECOV16_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] EP1_FIFO_ADDR = 8'h40;
  localparam int INT_W         = 7;
  localparam int INT_PKT_LSB   = 0;
  localparam int INT_SETUP_BIT = 5;
  localparam int INT_SUSP_BIT  = 6;
  localparam int CNT_W         = 7;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic       dma_grant_in;
    logic       mux_sel;
    logic [7:0] addr;
    logic [7:0] low;
    logic [7:0] high;
  } uhp_pin_type;

  typedef struct packed {
    logic        irq_pol_high;
    logic        dma_request_out_pol_high;
    logic        dma_grant_in_pol_low;
    logic        dma_single_mode;
    logic        dma_single_addr;
    logic        dma_wide;
    logic        ep1_tx;
  } uhp_cfg_type;

  typedef struct packed {
    logic        two;
    logic [15:0] data;
  } uhp_rx_word_type;

  typedef struct packed {
    logic        fifo;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } uhp_acc_type;

  typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_RECOV} uhp_dma_state_type;

  typedef struct packed {
    uhp_pin_type       sync1;
    uhp_pin_type       sync2;
    logic              rd_prev;
    logic              wr_prev;
    logic              ale_prev;
    logic [7:0]        addr_lat;
    logic              cs_lat_n;
    logic [15:0]       rdata;
    logic              lo_oe;
    logic              hi_oe;
    uhp_acc_type       acc;
    logic              acc_valid;
    logic [CNT_W-1:0]  remain;
    uhp_dma_state_type dma;
    logic [3:0]        recov;
    logic              dma_request_out;
    logic              irq;
  } uhp_state_type;

  localparam uhp_pin_type PIN_IDLE =
    '{cs_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1, default: '0};
  localparam uhp_state_type ST_RST = '{sync1: PIN_IDLE, sync2: PIN_IDLE,
    rd_prev: 1'h1, wr_prev: 1'h1, cs_lat_n: 1'h1, dma: DMA_IDLE,
    default: '0};
endpackage : uhp_pkg

// [logic/uhp_host_port.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// receive buffer between the endpoint engine and the host bus
module uhp_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_q != CW'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];
  assign push        = i_in_valid & o_in_ready & ~i_flush;
  assign pop         = o_out_valid & i_out_ready & ~i_flush;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'h1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'h1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule : uhp_fifo

// ============================================================
// application-side host port with endpoint 1 dma handshake
module uhp_host_port #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_bus_mux_select,
  input  wire logic [7:0]               i_separate_addr_in,
  input  wire logic [7:0]               i_muxed_low_byte,
  output logic [7:0]                    o_muxed_low_byte,
  output logic                          o_muxed_low_byte_oe,
  input  wire logic [7:0]               i_data_high_byte,
  output logic [7:0]                    o_data_high_byte,
  output logic                          o_data_high_byte_oe,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_rd_n,
  input  wire logic                     i_wr_n,
  input  wire logic                     i_ale,
  input  wire logic                     i_dma_grant_in,
  output logic                          o_irq_out,
  output logic                          o_dma_request_out,
  input  wire uhp_pkg::uhp_cfg_type     i_cfg,
  input  wire logic [uhp_pkg::INT_W-1:0] i_int_pending,
  input  wire logic [uhp_pkg::INT_W-1:0] i_int_enable,
  input  wire logic [15:0]              i_rd_data,
  output uhp_pkg::uhp_acc_type          o_acc,
  output logic                          o_acc_valid,
  input  wire logic                     i_rx_valid,
  output logic                          o_rx_ready,
  input  wire uhp_pkg::uhp_rx_word_type i_rx_word,
  input  wire logic                     i_ep1_pkt_arrive,
  input  wire logic [uhp_pkg::CNT_W-1:0] i_ep1_pkt_len,
  input  wire logic                     i_ep1_flush,
  input  wire logic                     i_ep1_tx_room,
  output logic                          o_ep1_full,
  output logic                          o_ep1_empty
);
  uhp_pkg::uhp_state_type   q;
  uhp_pkg::uhp_state_type   d;
  uhp_pkg::uhp_pin_type     pins;
  uhp_pkg::uhp_pin_type     s2;
  uhp_pkg::uhp_rx_word_type head;
  logic                     head_valid;
  logic                     pop;
  logic                     ale_fall;
  logic                     rd_fall;
  logic                     rd_rise;
  logic                     wr_rise;
  logic                     cs_sel;
  logic [7:0]               addr;
  logic                     dma_grant_in_act;
  logic                     dma_sel;
  logic                     reg_sel;
  logic                     sel;
  logic                     xfer;
  logic [1:0]               step;

  // ============================================================
  // receive buffer
  uhp_fifo #(
    .W     ($bits(uhp_pkg::uhp_rx_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (i_ep1_flush),
    .i_in_valid  (i_rx_valid),
    .o_in_ready  (o_rx_ready),
    .i_in_data   (i_rx_word),
    .o_out_valid (head_valid),
    .i_out_ready (pop),
    .o_out_data  (head)
  );

  assign o_ep1_full  = ~o_rx_ready;
  assign o_ep1_empty = ~head_valid;

  // ============================================================
  // decode
  always_comb begin
    pins = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n, ale: i_ale,
             dma_grant_in: i_dma_grant_in, mux_sel: i_bus_mux_select,
             addr: i_separate_addr_in, low: i_muxed_low_byte,
             high: i_data_high_byte};
  end

  assign s2       = q.sync2;
  assign ale_fall = s2.mux_sel & q.ale_prev & ~s2.ale;
  assign rd_fall  = q.rd_prev & ~s2.rd_n;
  assign rd_rise  = ~q.rd_prev & s2.rd_n;
  assign wr_rise  = ~q.wr_prev & s2.wr_n;
  assign cs_sel   = s2.mux_sel ? ~q.cs_lat_n : ~s2.cs_n;
  assign addr     = s2.mux_sel ? q.addr_lat : s2.addr;
  assign dma_grant_in_act = s2.dma_grant_in ^ i_cfg.dma_grant_in_pol_low;
  // grant alone selects in single address mode, else address does
  assign dma_sel  = i_cfg.dma_single_addr ? dma_grant_in_act
                  : cs_sel & (addr == uhp_pkg::EP1_FIFO_ADDR);
  assign reg_sel  = cs_sel & ~dma_sel
                  & ~(i_cfg.dma_single_addr & dma_grant_in_act);
  assign sel      = dma_sel | reg_sel;
  assign pop      = rd_fall & dma_sel & ~i_cfg.ep1_tx & head_valid;
  assign xfer     = i_cfg.ep1_tx ? (wr_rise & dma_sel) : pop;
  assign step     = (i_cfg.dma_wide & head.two) ? 2'h2 : 2'h1;

  // ============================================================
  // next state
  always_comb begin
    d           = q;
    d.sync1     = pins;
    d.sync2     = q.sync1;
    d.rd_prev   = s2.rd_n;
    d.wr_prev   = s2.wr_n;
    d.ale_prev  = s2.ale;
    d.acc_valid = 1'h0;
    if (ale_fall) begin
      d.addr_lat = s2.low;
      d.cs_lat_n = s2.cs_n;
    end
    if (rd_fall & sel) begin
      d.lo_oe = 1'h1;
      d.hi_oe = ~dma_sel | i_cfg.dma_wide;
      if (dma_sel) begin
        d.rdata = head_valid ? head.data : '0;
      end else begin
        d.rdata = i_rd_data;
      end
    end
    if (rd_rise | ~sel) begin
      d.lo_oe = 1'h0;
      d.hi_oe = 1'h0;
    end
    if (wr_rise & sel) begin
      d.acc_valid = 1'h1;
      d.acc.fifo  = dma_sel;
      d.acc.addr  = dma_sel ? uhp_pkg::EP1_FIFO_ADDR : addr;
      d.acc.wdata = {s2.high, s2.low};
    end
    if (i_ep1_flush | i_ep1_pkt_arrive) begin
      d.remain = i_ep1_flush ? '0 : i_ep1_pkt_len;
    end else if (pop) begin
      d.remain = (q.remain <= uhp_pkg::CNT_W'(step)) ? '0
               : q.remain - uhp_pkg::CNT_W'(step);
    end
    case (q.dma)
      uhp_pkg::DMA_IDLE: begin
        if (i_cfg.ep1_tx ? i_ep1_tx_room
            : (q.remain != '0) & head_valid) begin
          d.dma  = uhp_pkg::DMA_REQ;
          d.dma_request_out = 1'h1;
        end
      end
      uhp_pkg::DMA_REQ: begin
        if (i_cfg.dma_single_mode & xfer) begin
          d.dma   = uhp_pkg::DMA_RECOV;
          d.dma_request_out  = 1'h0;
          d.recov = i_cfg.dma_wide ? uhp_pkg::RECOV16_CYC
                  : uhp_pkg::RECOV8_CYC;
        end else if (i_cfg.ep1_tx ? ~i_ep1_tx_room
                     : (d.remain == '0)) begin
          d.dma  = uhp_pkg::DMA_IDLE;
          d.dma_request_out = 1'h0;
        end
      end
      uhp_pkg::DMA_RECOV: begin
        d.recov = q.recov - 4'h1;
        if (q.recov <= 4'h1) begin
          d.dma = uhp_pkg::DMA_IDLE;
        end
      end
      default: begin
        d.dma  = uhp_pkg::DMA_IDLE;
        d.dma_request_out = 1'h0;
      end
    endcase
    d.irq = |(i_int_pending & i_int_enable);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= uhp_pkg::ST_RST;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // outputs
  assign o_muxed_low_byte    = q.rdata[7:0];
  assign o_data_high_byte    = q.rdata[15:8];
  assign o_muxed_low_byte_oe = q.lo_oe;
  assign o_data_high_byte_oe = q.hi_oe;
  assign o_acc               = q.acc;
  assign o_acc_valid         = q.acc_valid;
  assign o_irq_out           = q.irq ^ ~i_cfg.irq_pol_high;
  assign o_dma_request_out   = q.dma_request_out ^ ~i_cfg.dma_request_out_pol_high;

  // ============================================================
  // assertions
  AST_SEP_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $past(~s2.mux_sel & wr_rise & reg_sel) |-> o_acc_valid
      && o_acc.addr == $past(s2.addr))
    else $error("separate address not used");
  AST_MUX_IGNORE: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $past(s2.mux_sel & wr_rise & reg_sel) |-> o_acc.addr == $past(q.addr_lat))
    else $error("separate address used in muxed mode");
  AST_ALE_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ale_fall |=> q.addr_lat == $past(s2.low))
    else $error("address not latched on strobe fall");
  AST_NO_SEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_acc_valid |-> $past(sel && wr_rise))
    else $error("write taken without select");
  AST_READ_DRIVE: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    rd_fall && sel |=> o_muxed_low_byte_oe)
    else $error("read did not drive bus");
  AST_WRITE_DATA: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    wr_rise && sel |=> o_acc_valid && o_acc.wdata[15:8] == $past(s2.high))
    else $error("write data lanes wrong");
  AST_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ##1 (o_irq_out ^ ~i_cfg.irq_pol_high)
      == $past(|(i_int_pending & i_int_enable)))
    else $error("interrupt does not follow enabled sources");
  AST_DEMAND_SET: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    q.dma == uhp_pkg::DMA_IDLE && !i_cfg.ep1_tx && q.remain != '0
      && head_valid |=> q.dma_request_out)
    else $error("demand request not raised");
  AST_DEMAND_HOLD: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    q.dma_request_out && !i_cfg.dma_single_mode && !i_cfg.ep1_tx
      && d.remain != '0 |=> q.dma_request_out)
    else $error("demand request dropped early");
  AST_SINGLE_DROP: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    q.dma_request_out && i_cfg.dma_single_mode && xfer |=> !q.dma_request_out [*7])
    else $error("single request not dropped for recovery");
  AST_DUAL_NO_DMA_GRANT_IN: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !i_cfg.dma_single_addr && !cs_sel |-> !dma_sel)
    else $error("grant used in dual address mode");
  AST_SINGLE_ADDR: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    i_cfg.dma_single_addr && dma_grant_in_act |-> dma_sel && !reg_sel)
    else $error("single address mode not selected by grant");

  COV_MUX_WRITE: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) ale_fall ##[1:40] wr_rise && reg_sel);
  COV_DEMAND: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) q.dma_request_out ##1 pop ##[1:40] !q.dma_request_out);
  COV_SINGLE: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) q.dma == uhp_pkg::DMA_RECOV ##[1:20] q.dma_request_out);
  COV_FULL: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) o_ep1_full);
endmodule : uhp_host_port
`default_nettype wire

// [sim/uhp_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// local host cpu and dma controller seen from the pins
module uhp_host_model (
  input  wire logic           i_core_clk,
  input  wire logic [7:0]     i_low_dev,
  input  wire logic           i_low_oe,
  input  wire logic [7:0]     i_high_dev,
  input  wire logic           i_high_oe,
  input  wire logic           i_dma_request_out,
  output uhp_pkg::uhp_pin_type o_pin
);
  uhp_pkg::uhp_pin_type drv;
  logic                 drv_en;
  logic [7:0]           low_q;
  logic [7:0]           high_q;

  initial begin
    drv    = uhp_pkg::PIN_IDLE;
    drv_en = 1'h0;
    low_q  = 8'h00;
    high_q = 8'h00;
  end

  // released lines toggle each cycle so no stale value can be read
  always @(posedge i_core_clk) begin
    low_q  <= o_pin.low;
    high_q <= o_pin.high;
  end

  always_comb begin
    o_pin = drv;
    if (drv.mux_sel) o_pin.addr = 8'hFF;
    o_pin.low  = i_low_oe ? i_low_dev : (drv_en ? drv.low : ~low_q);
    o_pin.high = i_high_oe ? i_high_dev : (drv_en ? drv.high : ~high_q);
  end

  // address phase on the low lines, taken at the latch strobe fall
  task automatic latch(input logic [7:0] a);
    @(negedge i_core_clk);
    drv.ale  = 1'h1;
    drv.cs_n = 1'h0;
    drv.low  = a;
    drv_en   = 1'h1;
    repeat (3) @(negedge i_core_clk);
    drv.ale = 1'h0;
    repeat (3) @(negedge i_core_clk);
    drv.cs_n = 1'h1;
    drv_en   = 1'h0;
  endtask : latch

  task automatic bus_wr(input logic cs, input logic [7:0] a,
                        input logic [15:0] d);
    @(negedge i_core_clk);
    drv.cs_n            = ~cs;
    drv.addr            = a;
    {drv.high, drv.low} = d;
    drv_en              = 1'h1;
    drv.wr_n            = 1'h0;
    repeat (4) @(negedge i_core_clk);
    drv.wr_n = 1'h1;
    repeat (4) @(negedge i_core_clk);
    drv.cs_n = 1'h1;
    drv_en   = 1'h0;
    repeat (3) @(negedge i_core_clk);
  endtask : bus_wr

  task automatic bus_rd(input logic cs, input logic dma_grant_in,
                        input logic [7:0] a, output logic [15:0] d,
                        output logic oe, output logic rq);
    @(negedge i_core_clk);
    drv.cs_n = ~cs;
    drv.dma_grant_in = dma_grant_in;
    drv.addr = a;
    drv.rd_n = 1'h0;
    repeat (7) @(negedge i_core_clk);
    d        = {o_pin.high, o_pin.low};
    oe       = i_low_oe;
    rq       = i_dma_request_out;
    drv.rd_n = 1'h1;
    drv.cs_n = 1'h1;
    drv.dma_grant_in = 1'h0;
    repeat (5) @(negedge i_core_clk);
  endtask : bus_rd
endmodule : uhp_host_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                       i_core_clk, i_rst_n;
  uhp_pkg::uhp_cfg_type       cfg;
  uhp_pkg::uhp_pin_type       pin;
  uhp_pkg::uhp_acc_type       acc, acc_last;
  uhp_pkg::uhp_rx_word_type   rx_word;
  logic [uhp_pkg::INT_W-1:0]  pend, en;
  logic [uhp_pkg::CNT_W-1:0]  pkt_len;
  logic [15:0]                rd_data, got;
  logic [7:0]                 low_o, high_o;
  logic                       rx_valid, rx_ready, arrive, flush, tx_room;
  logic                       low_oe, high_oe, irq, dma_request_out, acc_valid;
  logic                       full, empty, goe, grq, rdy;
  int                         error_cnt, n_tests, acc_cnt, n0;

  uhp_host_port dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_bus_mux_select(pin.mux_sel), .i_separate_addr_in(pin.addr),
    .i_muxed_low_byte(pin.low), .o_muxed_low_byte(low_o),
    .o_muxed_low_byte_oe(low_oe), .i_data_high_byte(pin.high),
    .o_data_high_byte(high_o), .o_data_high_byte_oe(high_oe),
    .i_cs_n(pin.cs_n), .i_rd_n(pin.rd_n), .i_wr_n(pin.wr_n),
    .i_ale(pin.ale), .i_dma_grant_in(pin.dma_grant_in), .o_irq_out(irq),
    .o_dma_request_out(dma_request_out), .i_cfg(cfg), .i_int_pending(pend),
    .i_int_enable(en), .i_rd_data(rd_data), .o_acc(acc),
    .o_acc_valid(acc_valid), .i_rx_valid(rx_valid),
    .o_rx_ready(rx_ready), .i_rx_word(rx_word),
    .i_ep1_pkt_arrive(arrive), .i_ep1_pkt_len(pkt_len),
    .i_ep1_flush(flush), .i_ep1_tx_room(tx_room),
    .o_ep1_full(full), .o_ep1_empty(empty));

  uhp_host_model u_host (
    .i_core_clk(i_core_clk), .i_low_dev(low_o), .i_low_oe(low_oe),
    .i_high_dev(high_o), .i_high_oe(high_oe), .i_dma_request_out(dma_request_out), .o_pin(pin));

  always #5 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk) begin
    if (acc_valid === 1'h1) begin
      acc_cnt  <= acc_cnt + 1;
      acc_last <= acc;
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %b", $time, m, g);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e,
                          input string m);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic push(input logic two, input logic [15:0] d);
    @(negedge i_core_clk);
    rx_word  = '{two: two, data: d};
    rx_valid = 1'h1;
    #1 rdy = rx_ready;
  endtask : push

  task automatic pkt(input logic [uhp_pkg::CNT_W-1:0] n);
    @(negedge i_core_clk);
    rx_valid = 1'h0;
    pkt_len  = n;
    arrive   = 1'h1;
    @(negedge i_core_clk);
    arrive = 1'h0;
    repeat (2) @(negedge i_core_clk);
  endtask : pkt

  initial begin
    #100000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    {i_core_clk, i_rst_n, rx_valid, arrive, flush, tx_room} = '0;
    {cfg, pend, en, rd_data, rx_word, pkt_len} = '0;
    {error_cnt, n_tests, acc_cnt} = '0;
    repeat (6) @(negedge i_core_clk);
    i_rst_n = 1'h1;
    chk_bit(low_oe, 1'h0, "low oe after reset");
    chk_bit(irq, 1'h1, "irq idle");
    chk_bit(dma_request_out, 1'h1, "dma_request_out idle");
    $display("test reset done");
    // separate address write, then the same without select
    u_host.latch(8'h99);
    n0 = acc_cnt;
    u_host.bus_wr(1'h1, 8'h56, 16'hA55A);
    chk_word(16'(acc_cnt - n0), 16'h0001, "write count");
    chk_word({8'h00, acc_last.addr}, 16'h0056, "addr");
    chk_word(acc_last.wdata, 16'hA55A, "wdata");
    n0 = acc_cnt;
    u_host.bus_wr(1'h0, 8'h13, 16'h1111);
    chk_word(16'(acc_cnt - n0), 16'h0000, "unselected write");
    rd_data = 16'hC3A5;
    u_host.bus_rd(1'h1, 1'h0, 8'h20, got, goe, grq);
    chk_bit(goe, 1'h1, "read oe");
    chk_word(got, 16'hC3A5, "read data");
    u_host.bus_rd(1'h0, 1'h0, 8'h20, got, goe, grq);
    chk_bit(goe, 1'h0, "unselected read");
    u_host.bus_rd(1'h0, 1'h1, 8'h00, got, goe, grq);
    chk_bit(goe, 1'h0, "grant in dual mode");
    $display("test plain bus done");
    @(negedge i_core_clk);
    u_host.drv.mux_sel = 1'h1;
    u_host.latch(8'h34);
    n0 = acc_cnt;
    u_host.bus_wr(1'h0, 8'h77, 16'h5AC3);
    chk_word(16'(acc_cnt - n0), 16'h0001, "muxed count");
    chk_word({8'h00, acc_last.addr}, 16'h0034, "muxed addr");
    chk_word(acc_last.wdata, 16'h5AC3, "muxed data");
    u_host.drv.mux_sel = 1'h0;
    $display("test muxed bus done");
    for (int i = 0; i < uhp_pkg::INT_W; i++) begin
      pend    = '0;
      pend[i] = 1'h1;
      en      = ~pend;
      repeat (3) @(negedge i_core_clk);
      chk_bit(irq, 1'h1, "masked source");
      en = pend;
      repeat (3) @(negedge i_core_clk);
      chk_bit(irq, 1'h0, "enabled source");
    end
    cfg.irq_pol_high  = 1'h1;
    cfg.dma_request_out_pol_high = 1'h1;
    repeat (3) @(negedge i_core_clk);
    chk_bit(irq, 1'h1, "irq high polarity");
    chk_bit(dma_request_out, 1'h0, "dma_request_out high polarity idle");
    cfg  = '0;
    pend = '0;
    $display("test interrupt done");
    cfg.dma_single_addr = 1'h1;
    for (int k = 1; k <= 3; k++) push(1'h0, 16'(k * 17));
    pkt(7'h03);
    chk_bit(dma_request_out, 1'h0, "demand request");
    for (int k = 1; k <= 3; k++) begin
      u_host.bus_rd(1'h0, 1'h1, 8'h00, got, goe, grq);
      chk_word({8'h00, got[7:0]}, 16'(k * 17), "dma byte");
      chk_bit(grq, 1'(k == 3), "demand hold");
    end
    cfg.dma_single_mode = 1'h1;
    cfg.dma_wide        = 1'h1;
    push(1'h1, 16'hBEEF);
    push(1'h1, 16'h1234);
    pkt(7'h04);
    chk_bit(dma_request_out, 1'h0, "single request");
    u_host.bus_rd(1'h0, 1'h1, 8'h00, got, goe, grq);
    chk_word(got, 16'hBEEF, "wide word");
    chk_bit(grq, 1'h1, "single drop");
    repeat (8) @(negedge i_core_clk);
    chk_bit(dma_request_out, 1'h0, "single re-raise");
    u_host.bus_rd(1'h0, 1'h1, 8'h00, got, goe, grq);
    chk_word(got, 16'h1234, "wide word two");
    repeat (15) @(negedge i_core_clk);
    chk_bit(dma_request_out, 1'h1, "packet done");
    cfg        = '0;
    cfg.ep1_tx = 1'h1;
    tx_room    = 1'h1;
    repeat (3) @(negedge i_core_clk);
    chk_bit(dma_request_out, 1'h0, "tx request");
    u_host.bus_wr(1'h1, uhp_pkg::EP1_FIFO_ADDR, 16'h2468);
    chk_bit(acc_last.fifo, 1'h1, "tx fifo write");
    chk_word({8'h00, acc_last.addr}, {8'h00, uhp_pkg::EP1_FIFO_ADDR},
             "tx addr");
    chk_word(acc_last.wdata, 16'h2468, "tx data");
    tx_room = 1'h0;
    repeat (3) @(negedge i_core_clk);
    chk_bit(dma_request_out, 1'h1, "tx request off");
    cfg = '0;
    $display("test dma done");
    chk_bit(empty, 1'h1, "empty flag");
    for (int k = 0; k < 9; k++) begin
      push(1'h0, 16'(k));
      chk_bit(rdy, 1'(k < 8), "buffer ready");
    end
    @(negedge i_core_clk);
    rx_valid = 1'h0;
    chk_bit(full, 1'h1, "full flag");
    flush = 1'h1;
    @(negedge i_core_clk);
    flush = 1'h0;
    repeat (2) @(negedge i_core_clk);
    chk_bit(empty, 1'h1, "empty after redo");
    $display("test buffer done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
